// ### common/pfs_pkg.sv
// Constants shared by the port frame statistics block.
// Assumes one 25 MHz system clock and eight switch ports numbered 1 to 8.
package pfs_pkg;
    // Port selection
    localparam int         NUM_PORTS  = 32'h8;
    localparam int         PORT_W     = 32'h4;
    localparam logic [3:0] FIRST_PORT = 4'h1;
    localparam logic [3:0] LAST_PORT  = 4'h8;
    // Data widths
    localparam int         LEN_W   = 32'h10;   // Frame length in bytes
    localparam int         CNT_W   = 32'h20;   // Every counter is 32 bits
    localparam int         NUM_CNT = 32'h15;   // Counters per port
    localparam int         IDX_W   = 32'h5;
    // Counter index map
    localparam logic [4:0] CNT_RXERR    = 5'h00;
    localparam logic [4:0] CNT_CRC      = 5'h01;
    localparam logic [4:0] CNT_OVERSIZE = 5'h02;
    localparam logic [4:0] CNT_FRAG     = 5'h03;
    localparam logic [4:0] CNT_JABBER   = 5'h04;
    localparam logic [4:0] CNT_COLL     = 5'h05;
    localparam logic [4:0] CNT_LATECOL  = 5'h06;
    localparam logic [4:0] CNT_TXBYTES  = 5'h07;
    localparam logic [4:0] CNT_TXGOOD   = 5'h08;
    localparam logic [4:0] CNT_RXBYTES  = 5'h09;
    localparam logic [4:0] CNT_RXGOOD   = 5'h0A;
    localparam logic [4:0] CNT_TOTBYTES = 5'h0B;
    localparam logic [4:0] CNT_MCAST    = 5'h0C;
    localparam logic [4:0] CNT_BCAST    = 5'h0D;
    localparam logic [4:0] CNT_BIN64    = 5'h0E;
    localparam logic [4:0] CNT_BIN127   = 5'h0F;
    localparam logic [4:0] CNT_BIN255   = 5'h10;
    localparam logic [4:0] CNT_BIN511   = 5'h11;
    localparam logic [4:0] CNT_BIN1023  = 5'h12;
    localparam logic [4:0] CNT_BIN1518  = 5'h13;
    localparam logic [4:0] CNT_TOTFRM   = 5'h14;
    // Length limits in bytes
    localparam logic [15:0] MIN_LEN   = 16'h0040;  // 64
    localparam logic [15:0] MAX_LEN   = 16'h05EE;  // 1518
    localparam logic [15:0] BIN_127   = 16'h007F;
    localparam logic [15:0] BIN_255   = 16'h00FF;
    localparam logic [15:0] BIN_511   = 16'h01FF;
    localparam logic [15:0] BIN_1023  = 16'h03FF;
    localparam logic [15:0] LATE_BYTE = 16'h0040;  // 64th byte onward
    // Rate sampling window
    localparam int RATE_WINDOW_NS     = 32'h3B9ACA00;  // One second
    localparam int CLK_PERIOD_NS      = 32'h28;        // 40 ns
    localparam int RATE_WINDOW_CYCLES = RATE_WINDOW_NS / CLK_PERIOD_NS;
endpackage

// ### hw/pfs_tick.sv
// One-pulse tick at the end of every rate sampling window.
// Assumes the system clock; the window length is a parameter.
`timescale 1ns/1ns
module pfs_tick #(
    parameter int unsigned CYCLES = 32'h0000000A
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // Window end pulse
    output logic      tick
);
    // Whole state of the divider
    typedef struct packed {
        logic [31:0] cnt;   // Cycles into window
        logic        tick;  // Registered pulse
    } pfs_tick_state_t;

    pfs_tick_state_t st_reg;
    pfs_tick_state_t st_next;

    // Count up, pulse and restart at the last cycle
    always_comb begin
        st_next      = st_reg;
        st_next.tick = 1'b0;
        if (st_reg.cnt >= 32'(CYCLES - 1)) begin
            st_next.cnt  = 32'h0;
            st_next.tick = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt + 32'h1;
        end
    end

    // State register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tick = st_reg.tick;
endmodule

// ### hw/pfs_stats.sv
// Per-port receive and transmit frame statistics for an eight-port switch.
// Assumes MAC event inputs are pulses synchronous to REF_CLK, one frame per port per cycle.
// How it works
// - Eight independent counter sets, ports 1-8
// - Count frames seen with receive error
// - Count valid-length frames with CRC/misalignment
// - Count good frames above 1518 bytes
// - Count good frames below 64 bytes
// - Count long frames with CRC/misalignment
// - Count every collision event
// - Also count collisions at byte 64+
// - Add sent bytes of good transmits
// - Count good transmitted frames
// - Add bytes of good received frames
// - Count good received frames
// - Add bytes of all received frames
// - Count good multicast received frames
// - Count good broadcast received frames
// - Sort received frames of up to 1518 bytes into six bins
// - Count every received frame
// - Clear sets only the selected port's counters to that cycle's increments
`timescale 1ns/1ns
module pfs_stats #(
    parameter int unsigned RATE_CYCLES = pfs_pkg::RATE_WINDOW_CYCLES
) (
    // Clock and reset
    input  wire logic                   REF_CLK,
    input  wire logic                   NRST,
    // Receive frame completion, one bit per port
    input  wire logic [7:0]             RX_DONE,
    input  wire logic [7:0][15:0]       RX_LEN,
    input  wire logic [7:0]             RX_MAC_ERR,
    input  wire logic [7:0]             RX_CRC_BAD,
    input  wire logic [7:0]             RX_ODD_NIBBLE,
    input  wire logic [7:0]             RX_MCAST,
    input  wire logic [7:0]             RX_BCAST,
    // Transmit frame completion
    input  wire logic [7:0]             TX_DONE,
    input  wire logic [7:0]             TX_OK,
    input  wire logic [7:0][15:0]       TX_LEN,
    // Collision events
    input  wire logic [7:0]             COL_EVENT,
    input  wire logic [7:0][15:0]       COL_BYTE_POS,
    // Management request
    input  wire logic [3:0]             SEL_PORT,
    input  wire logic [4:0]             SEL_CNT,
    input  wire logic                   RD_REQ,
    input  wire logic                   CLR_REQ,
    // Management answer
    output logic                        RD_VALID,
    output logic                        RD_BAD,
    output logic [31:0]                 RD_COUNT,
    output logic [31:0]                 RD_RATE
);
    localparam int NP = pfs_pkg::NUM_PORTS;
    localparam int NC = pfs_pkg::NUM_CNT;

    // Whole state of the block
    typedef struct packed {
        logic [NP-1:0][NC-1:0][31:0] cnt;   // Live counters
        logic [NP-1:0][NC-1:0][31:0] snap;  // Value at last window end
        logic [NP-1:0][NC-1:0][31:0] rate;  // Last window difference
        logic                        rd_valid;
        logic                        rd_bad;
        logic [31:0]                 rd_count;
        logic [31:0]                 rd_rate;
    } pfs_state_t;

    pfs_state_t                  st_reg;
    pfs_state_t                  st_next;
    logic [NP-1:0][NC-1:0][31:0] inc;        // Amount added this cycle
    logic [NP-1:0]               clr_hit;    // Port is being cleared
    logic                        win_tick;   // Rate window end
    logic                        sel_ok;     // Selected port in 1..8
    logic [2:0]                  sel_idx;    // Zero-based port

    // Widen a condition to a counter increment
    function automatic logic [31:0] one_if(input logic c);
        return {31'h00000000, c};
    endfunction

    // One-second window for the rate figures
    pfs_tick #(
        .CYCLES (RATE_CYCLES)
    ) u_tick (
        .clk  (REF_CLK),
        .nrst (NRST),
        .tick (win_tick)
    );

    assign sel_ok  = (SEL_PORT >= pfs_pkg::FIRST_PORT) && (SEL_PORT <= pfs_pkg::LAST_PORT);
    assign sel_idx = 3'(SEL_PORT - pfs_pkg::FIRST_PORT);

    // Per-port frame classification
    genvar p;
    generate
        for (p = 0; p < NP; p++) begin : g_port
            logic        rx;         // Any frame finished
            logic        good;       // No error of any kind
            logic        fcs_bad;    // CRC or odd nibble count
            logic [15:0] len;        // Received length
            logic        len_ok;     // 64..1518 bytes

            assign rx      = RX_DONE[p];
            assign len     = RX_LEN[p];
            assign fcs_bad = RX_CRC_BAD[p] | RX_ODD_NIBBLE[p];
            assign good    = ~RX_MAC_ERR[p] & ~fcs_bad;
            assign len_ok  = (len >= pfs_pkg::MIN_LEN) && (len <= pfs_pkg::MAX_LEN);
            assign clr_hit[p] = CLR_REQ && sel_ok && (sel_idx == 3'(p));

            assign inc[p][pfs_pkg::CNT_RXERR]    = one_if(rx & RX_MAC_ERR[p]);
            assign inc[p][pfs_pkg::CNT_CRC]      = one_if(rx & ~RX_MAC_ERR[p] & fcs_bad & len_ok);
            assign inc[p][pfs_pkg::CNT_OVERSIZE] = one_if(rx & good & (len > pfs_pkg::MAX_LEN));
            assign inc[p][pfs_pkg::CNT_FRAG]     = one_if(rx & good & (len < pfs_pkg::MIN_LEN));
            assign inc[p][pfs_pkg::CNT_JABBER]   = one_if(rx & fcs_bad & (len > pfs_pkg::MAX_LEN));
            assign inc[p][pfs_pkg::CNT_COLL]     = one_if(COL_EVENT[p]);
            // collision at or past byte 64
            assign inc[p][pfs_pkg::CNT_LATECOL]  = one_if(COL_EVENT[p] & (COL_BYTE_POS[p] >= pfs_pkg::LATE_BYTE));
            assign inc[p][pfs_pkg::CNT_TXBYTES]  = (TX_DONE[p] & TX_OK[p]) ? {16'h0000, TX_LEN[p]} : 32'h0;
            assign inc[p][pfs_pkg::CNT_TXGOOD]   = one_if(TX_DONE[p] & TX_OK[p]);
            assign inc[p][pfs_pkg::CNT_RXBYTES]  = (rx & good) ? {16'h0000, len} : 32'h0;
            assign inc[p][pfs_pkg::CNT_RXGOOD]   = one_if(rx & good);
            assign inc[p][pfs_pkg::CNT_TOTBYTES] = rx ? {16'h0000, len} : 32'h0;
            assign inc[p][pfs_pkg::CNT_MCAST]    = one_if(rx & good & RX_MCAST[p]);
            assign inc[p][pfs_pkg::CNT_BCAST]    = one_if(rx & good & RX_BCAST[p]);
            assign inc[p][pfs_pkg::CNT_BIN64]    = one_if(rx & (len <= pfs_pkg::MIN_LEN));
            assign inc[p][pfs_pkg::CNT_BIN127]   = one_if(rx & (len > pfs_pkg::MIN_LEN) & (len <= pfs_pkg::BIN_127));
            assign inc[p][pfs_pkg::CNT_BIN255]   = one_if(rx & (len > pfs_pkg::BIN_127) & (len <= pfs_pkg::BIN_255));
            assign inc[p][pfs_pkg::CNT_BIN511]   = one_if(rx & (len > pfs_pkg::BIN_255) & (len <= pfs_pkg::BIN_511));
            assign inc[p][pfs_pkg::CNT_BIN1023]  = one_if(rx & (len > pfs_pkg::BIN_511) & (len <= pfs_pkg::BIN_1023));
            assign inc[p][pfs_pkg::CNT_BIN1518]  = one_if(rx & (len > pfs_pkg::BIN_1023) & (len <= pfs_pkg::MAX_LEN));
            assign inc[p][pfs_pkg::CNT_TOTFRM]   = one_if(rx);
        end
    endgenerate

    // Counter update, rate sampling and management read
    always_comb begin
        st_next          = st_reg;
        st_next.rd_valid = RD_REQ;
        st_next.rd_bad   = 1'b0;
        for (int i = 0; i < NP; i++) begin
            for (int j = 0; j < NC; j++) begin
                if (win_tick) begin
                    st_next.rate[i][j] = st_reg.cnt[i][j] - st_reg.snap[i][j];
                    st_next.snap[i][j] = st_reg.cnt[i][j];
                end
                // clear one port, events still land
                if (clr_hit[i]) begin
                    st_next.rate[i][j] = 32'h0;
                    st_next.snap[i][j] = 32'h0;
                    st_next.cnt[i][j]  = inc[i][j];
                end else begin
                    st_next.cnt[i][j] = st_reg.cnt[i][j] + inc[i][j];
                end
            end
        end
        // Read returns values before this cycle's events
        if (RD_REQ) begin
            if (sel_ok && (SEL_CNT < 5'(NC))) begin
                st_next.rd_count = st_reg.cnt[sel_idx][SEL_CNT];
                st_next.rd_rate  = st_reg.rate[sel_idx][SEL_CNT];
            end else begin
                // Out of range select answers zero
                st_next.rd_bad   = 1'b1;
                st_next.rd_count = 32'h0;
                st_next.rd_rate  = 32'h0;
            end
        end
    end

    // State register; reset zeroes every counter
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from flops
    assign RD_VALID = st_reg.rd_valid;
    assign RD_BAD   = st_reg.rd_bad;
    assign RD_COUNT = st_reg.rd_count;
    assign RD_RATE  = st_reg.rd_rate;

    // Checks on port 1 and port 2 behaviour, and on the read answer for any selected port
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!NRST);

    a_rxerr_count: assert property (
        RX_DONE[0] && RX_MAC_ERR[0] && !clr_hit[0]
        |=> st_reg.cnt[0][pfs_pkg::CNT_RXERR] == $past(st_reg.cnt[0][pfs_pkg::CNT_RXERR]) + 32'h1)
        else $error("receive error frame not counted");

    a_jabber_count: assert property (
        RX_DONE[0] && RX_CRC_BAD[0] && (RX_LEN[0] > pfs_pkg::MAX_LEN) && !clr_hit[0]
        |=> st_reg.cnt[0][pfs_pkg::CNT_JABBER] == $past(st_reg.cnt[0][pfs_pkg::CNT_JABBER]) + 32'h1)
        else $error("jabber frame not counted");

    a_frag_hold: assert property (
        RX_DONE[0] && RX_MAC_ERR[0] && !clr_hit[0]
        |=> $stable(st_reg.cnt[0][pfs_pkg::CNT_FRAG]))
        else $error("errored frame counted as fragment");

    a_late_coll: assert property (
        COL_EVENT[0] && (COL_BYTE_POS[0] == 16'h003F) && !clr_hit[0]
        |=> $stable(st_reg.cnt[0][pfs_pkg::CNT_LATECOL])
            && st_reg.cnt[0][pfs_pkg::CNT_COLL] != $past(st_reg.cnt[0][pfs_pkg::CNT_COLL]))
        else $error("collision before byte 64 misclassified");

    a_tx_bytes: assert property (
        TX_DONE[0] && TX_OK[0] && !clr_hit[0]
        |=> st_reg.cnt[0][pfs_pkg::CNT_TXBYTES]
            == $past(st_reg.cnt[0][pfs_pkg::CNT_TXBYTES]) + {16'h0000, $past(TX_LEN[0])})
        else $error("transmitted bytes not added");

    a_bin_64: assert property (
        RX_DONE[0] && (RX_LEN[0] == 16'h0041) && !clr_hit[0]
        |=> $stable(st_reg.cnt[0][pfs_pkg::CNT_BIN64])
            && st_reg.cnt[0][pfs_pkg::CNT_BIN127] == $past(st_reg.cnt[0][pfs_pkg::CNT_BIN127]) + 32'h1)
        else $error("65 byte frame in wrong bin");

    a_port_indep: assert property (
        !RX_DONE[1] && !TX_DONE[1] && !COL_EVENT[1] && !clr_hit[1]
        |=> $stable(st_reg.cnt[1]))
        else $error("idle port counters changed");

    a_clear_port: assert property (
        clr_hit[1] && !RX_DONE[1] && !TX_DONE[1] && !COL_EVENT[1]
        |=> st_reg.cnt[1] == '0 && st_reg.rate[1] == '0)
        else $error("cleared port not zero");

    a_rate_sample: assert property (
        win_tick && !clr_hit[0]
        |=> st_reg.rate[0][pfs_pkg::CNT_TOTFRM]
            == $past(st_reg.cnt[0][pfs_pkg::CNT_TOTFRM]) - $past(st_reg.snap[0][pfs_pkg::CNT_TOTFRM]))
        else $error("rate not sampled at window end");

    a_read_answer: assert property (
        RD_REQ && sel_ok && (SEL_CNT == pfs_pkg::CNT_TOTFRM)
        |=> RD_VALID && !RD_BAD && RD_COUNT == $past(st_reg.cnt[sel_idx][pfs_pkg::CNT_TOTFRM]))
        else $error("read answer wrong");
endmodule

// ### test/pfs_mac_model.sv
// Behavioural model of the per-port MAC receive, transmit and collision paths.
// Assumes the bench calls its tasks one at a time; signals change on the falling edge.
`timescale 1ns/1ns
module pfs_mac_model (
    // Clock
    input  wire logic       clk,
    // Receive completion
    output logic [7:0]       rx_done,
    output logic [7:0][15:0] rx_len,
    output logic [7:0]       rx_mac_err,
    output logic [7:0]       rx_crc_bad,
    output logic [7:0]       rx_odd_nibble,
    output logic [7:0]       rx_mcast,
    output logic [7:0]       rx_bcast,
    // Transmit completion
    output logic [7:0]       tx_done,
    output logic [7:0]       tx_ok,
    output logic [7:0][15:0] tx_len,
    // Collision events
    output logic [7:0]       col_event,
    output logic [7:0][15:0] col_pos
);
    // Idle start, no events
    initial begin
        {rx_done, rx_mac_err, rx_crc_bad, rx_odd_nibble, rx_mcast, rx_bcast} = '0;
        {tx_done, tx_ok, col_event} = '0;
        rx_len = '0;
        tx_len = '0;
        col_pos = '0;
    end

    // One-cycle receive pulse; qualifiers turn to garbage after it
    task automatic rx_frame(input logic [2:0] p, input logic [15:0] len, input logic [4:0] fl);
        @(negedge clk);
        rx_done[p] = 1'b1;
        rx_len[p] = len;
        {rx_mac_err[p], rx_crc_bad[p], rx_odd_nibble[p], rx_mcast[p], rx_bcast[p]} = fl;
        @(negedge clk);
        rx_done[p] = 1'b0;
        rx_len[p] = ~len;
        {rx_mac_err[p], rx_crc_bad[p], rx_odd_nibble[p], rx_mcast[p], rx_bcast[p]} = ~fl;
    endtask

    // One-cycle transmit pulse with its success flag
    task automatic tx_frame(input logic [2:0] p, input logic [15:0] len, input logic ok);
        @(negedge clk);
        tx_done[p] = 1'b1;
        tx_ok[p] = ok;
        tx_len[p] = len;
        @(negedge clk);
        tx_done[p] = 1'b0;
        tx_ok[p] = ~ok;
        tx_len[p] = ~len;
    endtask

    // One-cycle collision pulse with byte offset
    task automatic collide(input logic [2:0] p, input logic [15:0] pos);
        @(negedge clk);
        col_event[p] = 1'b1;
        col_pos[p] = pos;
        @(negedge clk);
        col_event[p] = 1'b0;
        col_pos[p] = ~pos;
    endtask
endmodule

// ### test/tb_top.sv
// Self-checking bench for the port frame statistics block.
// Assumes a shortened rate window; all stimulus changes on the falling clock edge.
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; $display("mismatch at %0t: got %0h exp %0h", $time, g, e); end end
module tb_top;
    localparam int unsigned RATE_N = 50;  // Short window keeps the run brief
    // Table row: port, length, {mac,crc,odd,mcast,bcast}, counter, expected
    typedef struct {
        logic [2:0]  port;
        logic [15:0] len;
        logic [4:0]  fl;
        logic [4:0]  idx;
        logic [31:0] exp;
    } pfs_row_t;
    logic                   ref_clk;
    logic                   nrst;
    logic [7:0]             rx_done, rx_mac, rx_crc, rx_odd, rx_mc, rx_bc, tx_done, tx_ok, col_ev;
    logic [7:0][15:0]       rx_len, tx_len, col_pos;
    logic [3:0]             sel_port;
    logic [4:0]             sel_cnt;
    logic                   rd_req, clr_req, rd_valid, rd_bad, vld, bad;
    logic [31:0]            rd_count, rd_rate, v;
    int                     err_count, checked, n;
    pfs_row_t               rows [23];

    pfs_mac_model mac (.clk(ref_clk), .rx_done(rx_done), .rx_len(rx_len), .rx_mac_err(rx_mac),
        .rx_crc_bad(rx_crc), .rx_odd_nibble(rx_odd), .rx_mcast(rx_mc), .rx_bcast(rx_bc),
        .tx_done(tx_done), .tx_ok(tx_ok), .tx_len(tx_len), .col_event(col_ev), .col_pos(col_pos));
    pfs_stats #(.RATE_CYCLES(RATE_N)) uut (.REF_CLK(ref_clk), .NRST(nrst), .RX_DONE(rx_done),
        .RX_LEN(rx_len), .RX_MAC_ERR(rx_mac), .RX_CRC_BAD(rx_crc), .RX_ODD_NIBBLE(rx_odd),
        .RX_MCAST(rx_mc), .RX_BCAST(rx_bc), .TX_DONE(tx_done), .TX_OK(tx_ok), .TX_LEN(tx_len),
        .COL_EVENT(col_ev), .COL_BYTE_POS(col_pos), .SEL_PORT(sel_port), .SEL_CNT(sel_cnt),
        .RD_REQ(rd_req), .CLR_REQ(clr_req), .RD_VALID(rd_valid), .RD_BAD(rd_bad),
        .RD_COUNT(rd_count), .RD_RATE(rd_rate));

    // 25 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // Verdict and end of run
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Single read; valid and bad flags pulse one cycle, so all is taken while they stand
    task automatic rd(input logic [3:0] p, input logic [4:0] idx, output logic [31:0] c);
        @(negedge ref_clk);
        sel_port = p;
        sel_cnt = idx;
        rd_req = 1'b1;
        @(negedge ref_clk);
        rd_req = 1'b0;
        c = rd_count;
        vld = rd_valid;
        bad = rd_bad;
    endtask

    // Clear request for one port
    task automatic clr(input logic [3:0] p);
        @(negedge ref_clk);
        sel_port = p;
        clr_req = 1'b1;
        @(negedge ref_clk);
        clr_req = 1'b0;
    endtask

    // Watchdog, far beyond the expected few hundred cycles
    initial begin
        #(40 * 20000);
        err_count++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        {nrst, rd_req, clr_req, sel_port, sel_cnt} = '0;
        err_count = 0;
        checked = 0;
        rows = '{'{3'h0, 16'h0064, 5'h00, 5'h0A, 32'h1}, '{3'h1, 16'h0064, 5'h00, 5'h09, 32'h64},
                 '{3'h0, 16'h0064, 5'h10, 5'h00, 32'h1}, '{3'h3, 16'h0064, 5'h10, 5'h0A, 32'h0},
                 '{3'h4, 16'h0064, 5'h08, 5'h01, 32'h1}, '{3'h5, 16'h0064, 5'h04, 5'h01, 32'h1},
                 '{3'h6, 16'h05EF, 5'h00, 5'h02, 32'h1}, '{3'h7, 16'h05EE, 5'h00, 5'h02, 32'h0},
                 '{3'h0, 16'h003F, 5'h00, 5'h03, 32'h1}, '{3'h1, 16'h0040, 5'h00, 5'h03, 32'h0},
                 '{3'h0, 16'h05EF, 5'h08, 5'h04, 32'h1}, '{3'h3, 16'h05EF, 5'h08, 5'h01, 32'h0},
                 '{3'h4, 16'h00C8, 5'h08, 5'h0B, 32'hC8}, '{3'h5, 16'h00C8, 5'h10, 5'h14, 32'h1},
                 '{3'h6, 16'h0050, 5'h02, 5'h0C, 32'h1}, '{3'h7, 16'h0050, 5'h0A, 5'h0C, 32'h0},
                 '{3'h0, 16'h0050, 5'h01, 5'h0D, 32'h1}, '{3'h0, 16'h0041, 5'h00, 5'h0F, 32'h1},
                 '{3'h2, 16'h0080, 5'h00, 5'h10, 32'h1}, '{3'h3, 16'h0200, 5'h00, 5'h12, 32'h1},
                 '{3'h4, 16'h05EE, 5'h08, 5'h13, 32'h1}, '{3'h5, 16'h01FF, 5'h00, 5'h11, 32'h1},
                 '{3'h6, 16'h0040, 5'h00, 5'h0E, 32'h1}};
        repeat (8) @(negedge ref_clk);
        // Quiet outputs during reset
        `CHK(rd_valid, 1'b0)
        nrst = 1'b1;
        rd(4'h1, 5'h14, v);
        `CHK(v, 32'h0)
        `CHK(vld, 1'b1)
        `CHK(bad, 1'b0)
        $display("test reset done");
        // Classification table, each row on a freshly cleared port
        foreach (rows[i]) begin
            clr({1'b0, rows[i].port} + 4'h1);
            mac.rx_frame(rows[i].port, rows[i].len, rows[i].fl);
            rd({1'b0, rows[i].port} + 4'h1, rows[i].idx, v);
            `CHK(v, rows[i].exp)
        end
        $display("test table done");
        // Transmit: refused frame adds nothing
        clr(4'h1);
        mac.tx_frame(3'h0, 16'h012C, 1'b1);
        mac.tx_frame(3'h0, 16'h01F4, 1'b0);
        mac.tx_frame(3'h0, 16'h003C, 1'b1);
        rd(4'h1, 5'h07, v);
        `CHK(v, 32'h168)
        rd(4'h1, 5'h08, v);
        `CHK(v, 32'h2)
        $display("test transmit done");
        // Collisions at the late boundary
        clr(4'h1);
        mac.collide(3'h0, 16'h003F);
        mac.collide(3'h0, 16'h0040);
        rd(4'h1, 5'h05, v);
        `CHK(v, 32'h2)
        rd(4'h1, 5'h06, v);
        `CHK(v, 32'h1)
        $display("test collision done");
        // Clearing one port leaves its neighbour alone
        mac.rx_frame(3'h7, 16'h0064, 5'h00);
        mac.rx_frame(3'h6, 16'h0064, 5'h00);
        clr(4'h7);
        rd(4'h8, 5'h14, v);
        `CHK(v, 32'h2)
        rd(4'h7, 5'h14, v);
        `CHK(v, 32'h0)
        $display("test clear done");
        // Out-of-range selections are flagged
        rd(4'h0, 5'h00, v);
        `CHK(bad, 1'b1)
        rd(4'h1, 5'h15, v);
        `CHK(bad, 1'b1)
        `CHK(v, 32'h0)
        $display("test bad select done");
        // One frame shows as rate 1 for exactly one window
        clr(4'h3);
        mac.rx_frame(3'h2, 16'h0064, 5'h00);
        @(negedge ref_clk);
        sel_port = 4'h3;
        sel_cnt = 5'h14;
        rd_req = 1'b1;
        n = 0;
        repeat (120) begin
            @(negedge ref_clk);
            if (rd_valid === 1'b1 && rd_rate === 32'h1) n++;
        end
        rd_req = 1'b0;
        `CHK(n, RATE_N)
        $display("test rate done");
        // Reset in mid-run clears counters
        @(negedge ref_clk);
        nrst = 1'b0;
        @(negedge ref_clk);
        nrst = 1'b1;
        rd(4'h8, 5'h14, v);
        `CHK(v, 32'h0)
        $display("test mid reset done");
        report_and_stop();
    end
endmodule
